// File: inc/mbw_params.svh
// constants for the multi-write and identification telegram handler
// Functional notes
// - function 0x0F writes consecutive bits, count one ok
// - coil request field order, byte count, data, crc
// - coil reply echoes address and count, no data
// - coil data bit 0 is first bit
// - master zeroes unused bits of last byte
// - function 0x10 writes consecutive registers, count one ok
// - register request field order, values high then low
// - register reply echoes start and count plus crc
// - two bytes per address and count field, high byte first
// - function 0x2B with MEI 0x0E returns identification
// - reply fields then code, length, characters per object
// - basic category only: objects 00, 01, 02
// - revision object formatted as V digit point digits
// - reading code 01 sequence, 04 single object
// - conformity 0x51, more-follows and next-object zero
// - register is 16 bits, two bytes high first
`ifndef MBW_PARAMS_SVH
`define MBW_PARAMS_SVH
`define MBW_FN_COILS   8'h0F
`define MBW_FN_REGS    8'h10
`define MBW_FN_IDENT   8'h2B
`define MBW_MEI_DEVID  8'h0E
`define MBW_RD_BASIC   8'h01
`define MBW_RD_SINGLE  8'h04
`define MBW_CONFORM    8'h51
`define MBW_ZERO_BYTE  8'h00
`define MBW_OBJ_LAST   8'h02
`define MBW_CRC_INIT   16'hFFFF
`define MBW_CRC_POLY   16'hA001
`define MBW_FRAME_MAX  7'h40
`define MBW_WR_HDR     6'h06
`define MBW_ID_HDR     6'h08
`define MBW_REQ_OVH    7'h09
`define MBW_ID_REQ_LEN 7'h07
`define MBW_MAX_COILS  6'h20
`define MBW_MAX_REGS   3'h4
`endif

// File: inc/mbw_pkg.sv
// shared types and checksum step for the telegram handler
`include "mbw_params.svh"
package mbw_pkg;
   typedef logic [7:0]  mbw_byte_t;
   typedef logic [15:0] mbw_word_t;

   // one byte step of the reflected modbus checksum
   function automatic mbw_word_t mbw_crc_step(input mbw_word_t crc, input mbw_byte_t b);
      mbw_word_t c;
      c = crc ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ `MBW_CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction
endpackage

// File: inc/mbw_link_if.sv
// byte stream link between bus master and slave
`timescale 1ns/1ps
`default_nettype none
interface mbw_link_if;
   logic [7:0] m2s_data;
   logic       m2s_valid;
   logic       m2s_last;
   logic [7:0] s2m_data;
   logic       s2m_valid;
   logic       s2m_last;
   modport slave  (input m2s_data, m2s_valid, m2s_last, output s2m_data, s2m_valid, s2m_last);
   modport master (output m2s_data, m2s_valid, m2s_last, input s2m_data, s2m_valid, s2m_last);
endinterface
`default_nettype wire

// File: core/mbw_slave.sv
// slave end: receives requests, performs writes, returns replies
`timescale 1ns/1ps
`default_nettype none
`include "mbw_params.svh"
module mbw_slave
   import mbw_pkg::*;
#(
   // identification strings, values arbitrary
   parameter logic [8*4-1:0] VENDOR_STR  = "ACME",
   parameter logic [8*8-1:0] PRODUCT_STR = "PROD 10A",
   parameter logic [8*5-1:0] REVISION_STR = "V1.00"
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // own station address
   input  wire logic [7:0]  own_addr,
   // link
   mbw_link_if.slave        link,
   // coil write strobe
   output logic             coil_wr,
   output logic [15:0]      coil_addr,
   output logic             coil_val,
   // register write strobe
   output logic             reg_wr,
   output logic [15:0]      reg_addr,
   output logic [15:0]      reg_data
);
   //////////////////////////////
   // identification table: code, length, characters per object
   localparam int ROM_N = 23;
   localparam logic [8*ROM_N-1:0] ID_ROM = {8'h00, 8'h04, VENDOR_STR,
                                           8'h01, 8'h08, PRODUCT_STR,
                                           8'h02, 8'h05, REVISION_STR};

   function automatic mbw_byte_t rom_byte(input logic [4:0] i);
      return ID_ROM[8*(ROM_N-1-int'(i)) +: 8];
   endfunction

   // start offset of an object in the table
   function automatic logic [4:0] obj_off(input logic [1:0] o);
      unique case (o)
         2'h0:    return 5'h00;
         2'h1:    return 5'h06;
         2'h2:    return 5'h10;
         default: return 5'h17;
      endcase
   endfunction

   //////////////////////////////
   typedef enum {S_RX, S_CHECK, S_EXEC, S_TX} mbw_sstate_t;
   mbw_sstate_t state;

   mbw_byte_t  frame [64];
   logic [6:0] rx_len;
   logic       rx_ovf;
   mbw_word_t  rx_crc;
   mbw_word_t  tx_crc;
   logic [15:0] wr_idx;
   logic [5:0] tx_idx;
   logic [5:0] body_len;
   logic [1:0] tx_tail;
   logic [4:0] id_lo;
   logic [4:0] id_hi;
   logic [7:0] id_cnt;

   wire mbw_word_t start_w = {frame[2], frame[3]};
   wire mbw_word_t count_w = {frame[4], frame[5]};
   wire logic      id_single = (frame[3] == `MBW_RD_SINGLE);

   //////////////////////////////
   // request acceptance checks
   logic addr_ok, crc_ok, coil_ok, reg_ok, id_ok;
   always_comb begin
      addr_ok = !rx_ovf && (frame[0] == own_addr);
      crc_ok  = (rx_crc == 16'h0000);
      coil_ok = (frame[1] == `MBW_FN_COILS) && (rx_len == `MBW_REQ_OVH + {1'b0, frame[6]})
                && ({8'h00, frame[6]} == ((count_w + 16'h0007) >> 3));
      reg_ok  = (frame[1] == `MBW_FN_REGS) && (rx_len == `MBW_REQ_OVH + {1'b0, frame[6]})
                && ({8'h00, frame[6]} == {count_w[14:0], 1'b0});
      id_ok   = (frame[1] == `MBW_FN_IDENT) && (rx_len == `MBW_ID_REQ_LEN)
                && (frame[2] == `MBW_MEI_DEVID) && (frame[4] <= `MBW_OBJ_LAST)
                && (frame[3] == `MBW_RD_BASIC || id_single);
   end

   //////////////////////////////
   // reply byte at a body position
   function automatic mbw_byte_t body_byte(input logic [5:0] i);
      if (frame[1] != `MBW_FN_IDENT) begin
         return frame[i];
      end
      unique case (i)
         6'h00, 6'h01, 6'h02, 6'h03: return frame[i];
         6'h04:   return `MBW_CONFORM;
         6'h05:   return `MBW_ZERO_BYTE;
         6'h06:   return `MBW_ZERO_BYTE;
         6'h07:   return id_cnt;
         default: return rom_byte(5'(id_lo + 5'(i - `MBW_ID_HDR)));
      endcase
   endfunction

   //////////////////////////////
   // sequencer
   always_ff @(posedge clk) begin
      if (reset) begin
         state    <= S_RX;
         rx_len   <= 7'h00;
         rx_ovf   <= 1'b0;
         rx_crc   <= `MBW_CRC_INIT;
      end else begin
         unique case (state)
            S_RX: begin
               if (link.m2s_valid) begin
                  // overlong frame: dropped at check
                  if (rx_len == `MBW_FRAME_MAX) begin
                     rx_ovf <= 1'b1;
                  end else begin
                     rx_len <= rx_len + 7'h01;
                  end
                  rx_crc <= mbw_crc_step(rx_crc, link.m2s_data);
                  if (link.m2s_last) begin
                     state <= S_CHECK;
                  end
               end
            end
            S_CHECK: begin
               wr_idx <= 16'h0000;
               tx_idx <= 6'h00;
               tx_tail <= 2'h0;
               tx_crc <= `MBW_CRC_INIT;
               id_lo  <= obj_off(frame[4][1:0]);
               id_hi  <= id_single ? obj_off(2'(frame[4][1:0] + 2'h1)) : obj_off(2'h3);
               id_cnt <= id_single ? 8'h01 : 8'h03 - frame[4];
               body_len <= (frame[1] == `MBW_FN_IDENT) ? `MBW_ID_HDR : `MBW_WR_HDR;
               if (addr_ok && crc_ok && (coil_ok || reg_ok)) begin
                  state <= S_EXEC;
               end else if (addr_ok && crc_ok && id_ok) begin
                  state <= S_TX;
               end else begin
                  state <= S_RX;
               end
               rx_len <= 7'h00;
               rx_ovf <= 1'b0;
               rx_crc <= `MBW_CRC_INIT;
            end
            S_EXEC: begin
               if (wr_idx == count_w) begin
                  state <= S_TX;
               end else begin
                  wr_idx <= wr_idx + 16'h0001;
               end
            end
            S_TX: begin
               // length known before the header ends, so no byte is skipped
               if (frame[1] == `MBW_FN_IDENT && tx_idx == 6'h00) begin
                  body_len <= 6'(`MBW_ID_HDR + 6'(id_hi - id_lo));
               end
               if (tx_idx < body_len) begin
                  tx_crc <= mbw_crc_step(tx_crc, body_byte(tx_idx));
                  tx_idx <= tx_idx + 6'h01;
               end else if (tx_tail == 2'h0) begin
                  tx_tail <= 2'h1;
               end else begin
                  state <= S_RX;
               end
            end
         endcase
      end
   end

   //////////////////////////////
   // write strobes toward the parameter store
   always_ff @(posedge clk) begin
      if (reset) begin
         coil_wr   <= 1'b0;
         coil_addr <= 16'h0000;
         coil_val  <= 1'b0;
         reg_wr    <= 1'b0;
         reg_addr  <= 16'h0000;
         reg_data  <= 16'h0000;
      end else begin
         coil_wr <= 1'b0;
         reg_wr  <= 1'b0;
         if (state == S_EXEC && wr_idx != count_w) begin
            if (frame[1] == `MBW_FN_COILS) begin
               coil_wr   <= 1'b1;
               coil_addr <= start_w + wr_idx;
               coil_val  <= frame[6'(7 + int'(wr_idx[15:3]))][wr_idx[2:0]];
            end else begin
               reg_wr   <= 1'b1;
               reg_addr <= start_w + wr_idx;
               reg_data <= {frame[6'(7 + 2*int'(wr_idx))],
                            frame[6'(8 + 2*int'(wr_idx))]};
            end
         end
      end
   end

   //////////////////////////////
   // capture of incoming bytes; overflow bytes are not stored
   always_ff @(posedge clk) begin
      if (state == S_RX && link.m2s_valid && rx_len != `MBW_FRAME_MAX) begin
         frame[rx_len[5:0]] <= link.m2s_data;
      end
   end

   //////////////////////////////
   // reply output; checksum goes low byte first
   always_ff @(posedge clk) begin
      if (reset) begin
         link.s2m_valid <= 1'b0;
         link.s2m_data  <= 8'h00;
         link.s2m_last  <= 1'b0;
      end else begin
         link.s2m_valid <= 1'b0;
         link.s2m_last  <= 1'b0;
         if (state == S_TX) begin
            link.s2m_valid <= 1'b1;
            if (tx_idx < body_len) begin
               link.s2m_data <= body_byte(tx_idx);
            end else if (tx_tail == 2'h0) begin
               link.s2m_data <= tx_crc[7:0];
            end else begin
               link.s2m_data <= tx_crc[15:8];
               link.s2m_last <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: core/mbw_master.sv
// master end: builds requests from user commands, returns replies
`timescale 1ns/1ps
`default_nettype none
`include "mbw_params.svh"
module mbw_master
   import mbw_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // command
   input  wire logic        cmd_start,
   input  wire logic [7:0]  cmd_station,
   input  wire logic [7:0]  cmd_func,
   input  wire logic [15:0] cmd_first,
   input  wire logic [15:0] cmd_count,
   input  wire logic [31:0] cmd_coils,
   input  wire logic [63:0] cmd_regs,
   input  wire logic [7:0]  cmd_read_code,
   input  wire logic [7:0]  cmd_object,
   output logic             cmd_ready,
   // reply bytes
   output logic             rsp_valid,
   output logic [7:0]       rsp_data,
   output logic             rsp_done,
   output logic             rsp_crc_ok,
   // link
   mbw_link_if.master       link
);
   //////////////////////////////
   typedef enum {M_IDLE, M_TX, M_RX} mbw_mstate_t;
   mbw_mstate_t state;

   logic [7:0]  station, func, rd_code, obj;
   logic [15:0] first, count;
   logic [31:0] coils;
   logic [63:0] regs;
   logic [5:0]  idx;
   logic [5:0]  body_len;
   mbw_word_t   crc;
   logic [1:0]  tail;

   // data byte count of a write request
   wire logic [7:0] data_bytes = (func == `MBW_FN_COILS) ?
                                 8'((count + 16'h0007) >> 3) : 8'({count[14:0], 1'b0});

   // request byte at a body position
   function automatic mbw_byte_t req_byte(input logic [5:0] i);
      logic [5:0] d;
      d = 6'(i - 6'h07);
      if (func == `MBW_FN_IDENT) begin
         unique case (i)
            6'h00:   return station;
            6'h01:   return func;
            6'h02:   return `MBW_MEI_DEVID;
            6'h03:   return rd_code;
            default: return obj;
         endcase
      end
      unique case (i)
         6'h00:   return station;
         6'h01:   return func;
         6'h02:   return first[15:8];
         6'h03:   return first[7:0];
         6'h04:   return count[15:8];
         6'h05:   return count[7:0];
         6'h06:   return data_bytes;
         default: return (func == `MBW_FN_COILS) ? coils[8*d[1:0] +: 8]
                                               : regs[64-8*(int'(d[2:0])+1) +: 8];
      endcase
   endfunction

   // keep only the requested coils, upper bits zero
   function automatic logic [31:0] coil_mask(input logic [31:0] v, input logic [15:0] n);
      logic [31:0] m;
      for (int i = 0; i < 32; i++) begin
         m[i] = (16'(i) < n);
      end
      return v & m;
   endfunction

   //////////////////////////////
   // command capture and sequencing; command fields load on start
   always_ff @(posedge clk) begin
      if (reset) begin
         state <= M_IDLE;
         crc <= `MBW_CRC_INIT;
      end else begin
         unique case (state)
            M_IDLE: begin
               if (cmd_start) begin
                  station <= cmd_station;
                  func    <= cmd_func;
                  rd_code <= cmd_read_code;
                  obj     <= cmd_object;
                  first   <= cmd_first;
                  count   <= cmd_count;
                  coils   <= coil_mask(cmd_coils, cmd_count);
                  regs    <= cmd_regs;
                  idx     <= 6'h00;
                  tail    <= 2'h0;
                  crc     <= `MBW_CRC_INIT;
                  body_len <= (cmd_func == `MBW_FN_IDENT) ? 6'h05 :
                              (cmd_func == `MBW_FN_COILS) ?
                              6'(7 + ((cmd_count + 16'h0007) >> 3)) :
                              6'(7 + 2*cmd_count);
                  state <= M_TX;
               end
            end
            M_TX: begin
               if (idx < body_len) begin
                  crc <= mbw_crc_step(crc, req_byte(idx));
                  idx <= idx + 6'h01;
               end else if (tail == 2'h0) begin
                  tail <= 2'h1;
               end else begin
                  crc   <= `MBW_CRC_INIT;
                  state <= M_RX;
               end
            end
            M_RX: begin
               if (link.s2m_valid) begin
                  crc <= mbw_crc_step(crc, link.s2m_data);
                  if (link.s2m_last) begin
                     state <= M_IDLE;
                  end
               end
            end
         endcase
      end
   end

   //////////////////////////////
   // request output; checksum low byte then high byte
   always_ff @(posedge clk) begin
      if (reset) begin
         link.m2s_valid <= 1'b0;
         link.m2s_data  <= 8'h00;
         link.m2s_last  <= 1'b0;
      end else begin
         link.m2s_valid <= 1'b0;
         link.m2s_last  <= 1'b0;
         if (state == M_TX) begin
            link.m2s_valid <= 1'b1;
            if (idx < body_len) begin
               link.m2s_data <= req_byte(idx);
            end else if (tail == 2'h0) begin
               link.m2s_data <= crc[7:0];
            end else begin
               link.m2s_data <= crc[15:8];
               link.m2s_last <= 1'b1;
            end
         end
      end
   end

   //////////////////////////////
   // reply forwarding and checksum verdict
   always_ff @(posedge clk) begin
      if (reset) begin
         rsp_valid  <= 1'b0;
         rsp_data   <= 8'h00;
         rsp_done   <= 1'b0;
         rsp_crc_ok <= 1'b0;
         cmd_ready  <= 1'b0;
      end else begin
         rsp_valid <= (state == M_RX) && link.s2m_valid;
         rsp_done  <= (state == M_RX) && link.s2m_valid && link.s2m_last;
         cmd_ready <= (state == M_IDLE) && !cmd_start;
         if (state == M_RX && link.s2m_valid) begin
            rsp_data <= link.s2m_data;
            if (link.s2m_last) begin
               rsp_crc_ok <= (mbw_crc_step(crc, link.s2m_data) == 16'h0000);
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/mbw_link_checker.sv
// assertions on the byte link joining the master and slave ends
`timescale 1ns/1ps
`default_nettype none
module mbw_link_checker (
   // clock and reset
   input wire logic       clk,
   input wire logic       reset,
   // request stream
   input wire logic [7:0] m2s_data,
   input wire logic       m2s_valid,
   input wire logic       m2s_last,
   // reply stream
   input wire logic [7:0] s2m_data,
   input wire logic       s2m_valid,
   input wire logic       s2m_last
);
   logic [7:0] rx_idx;
   logic [7:0] tx_idx;
   logic [7:0] req [0:5];
   logic       ident;

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   //////////////////////////////
   // byte position within the current request
   always_ff @(posedge clk) begin
      if (reset) begin
         rx_idx <= 8'h00;
      end else if (m2s_valid) begin
         rx_idx <= m2s_last ? 8'h00 : rx_idx + 8'h01;
      end
   end
   // request header for echo checks
   always_ff @(posedge clk) begin
      if (m2s_valid && rx_idx < 8'h06) begin
         req[rx_idx[2:0]] <= m2s_data;
      end
   end
   // byte position within the current reply
   always_ff @(posedge clk) begin
      if (reset) begin
         tx_idx <= 8'h00;
      end else if (s2m_valid) begin
         tx_idx <= s2m_last ? 8'h00 : tx_idx + 8'h01;
      end
   end
   assign ident = (req[1] == 8'h2B);

   //////////////////////////////
   a_last_valid: assert property (m2s_last |-> m2s_valid)
      else $error("request last byte without strobe");
   a_req_stream: assert property (m2s_valid && !m2s_last |=> m2s_valid)
      else $error("gap inside request");
   a_rsp_stream: assert property (s2m_valid && !s2m_last |=> s2m_valid)
      else $error("gap inside reply");
   a_reply_bound: assert property (m2s_valid && m2s_last |-> ##[2:60] s2m_valid)
      else $error("no reply to request");
   a_ident_latency: assert property (m2s_valid && m2s_last && ident |-> ##3 s2m_valid)
      else $error("identification reply late");
   a_echo_fields: assert property (s2m_valid && (tx_idx < 8'h04 || (tx_idx < 8'h06 && !ident))
      |-> s2m_data == req[tx_idx[2:0]])
      else $error("reply header differs from request");
   a_write_len: assert property (s2m_valid && s2m_last && !ident |-> tx_idx == 8'h07)
      else $error("write reply length wrong");
   a_conform_level: assert property (s2m_valid && ident && tx_idx == 8'h04
      |-> s2m_data == 8'h51)
      else $error("conformity level wrong");
   a_more_zero: assert property (s2m_valid && ident && (tx_idx == 8'h05 || tx_idx == 8'h06)
      |-> s2m_data == 8'h00)
      else $error("more-follows or next-object not zero");
   a_object_count: assert property (s2m_valid && ident && tx_idx == 8'h07
      |-> s2m_data inside {8'h01, 8'h02, 8'h03})
      else $error("object count out of range");
   a_first_object: assert property (s2m_valid && ident && tx_idx == 8'h08
      |-> s2m_data == req[4])
      else $error("first object code not the requested one");
endmodule
`default_nettype wire

// File: dv/modbus_multi_write_ident_slave_tb.sv
// bench: master and slave joined, plus a slave fed raw frames
`timescale 1ns/1ps
`default_nettype none
module modbus_multi_write_ident_slave_tb;
   import mbw_pkg::*;
   typedef logic [7:0] mbw_bq_t[$];
   // identification strings, values arbitrary
   localparam logic [31:0] VEND = "ZETA";
   localparam logic [63:0] PROD = "UNIT 12A";
   localparam logic [39:0] REV  = "V3.14";
   logic        clk, reset, cmd_start, cmd_ready, rsp_valid, rsp_done, rsp_crc_ok;
   logic        coil_wr, coil_val, reg_wr;
   logic [7:0]  own_addr, cmd_station, cmd_func, cmd_read_code, cmd_object, rsp_data;
   logic [15:0] cmd_first, cmd_count, coil_addr, reg_addr, reg_data;
   logic [31:0] cmd_coils;
   logic [63:0] cmd_regs;
   int          failures, cmp_count, cycles;
   mbw_bq_t     mq, rq, bq;
   logic [31:0] wq[$];
   logic [15:0] cf[4] = '{16'h0064, 16'h0007, 16'h1000, 16'h0000};
   logic [15:0] cn[4] = '{16'h0003, 16'h000A, 16'h0001, 16'h0020};
   logic [31:0] cb[4] = '{32'hFFFFFFF3, 32'hFFFFFEA5, 32'h00000001, 32'hA5C30F81};
   logic [7:0]  rs[3] = '{8'h14, 8'h01, 8'h22};
   logic [15:0] rf[3] = '{16'h0064, 16'h00FF, 16'h7FFE};
   logic [7:0]  rn[3] = '{8'h02, 8'h01, 8'h04};
   logic [63:0] rv[3] = '{64'h000A001400000000, 64'hBEEF000000000000, 64'h12348001FFFF0000};

   mbw_link_if link ();
   mbw_link_if link_b ();
   mbw_master u_mbw_master (.clk(clk), .reset(reset), .cmd_start(cmd_start),
      .cmd_station(cmd_station), .cmd_func(cmd_func), .cmd_first(cmd_first),
      .cmd_count(cmd_count), .cmd_coils(cmd_coils), .cmd_regs(cmd_regs),
      .cmd_read_code(cmd_read_code), .cmd_object(cmd_object), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_done(rsp_done),
      .rsp_crc_ok(rsp_crc_ok), .link(link));
   mbw_slave #(.VENDOR_STR(VEND), .PRODUCT_STR(PROD), .REVISION_STR(REV)) u_mbw_slave (
      .clk(clk), .reset(reset), .own_addr(own_addr), .link(link), .coil_wr(coil_wr),
      .coil_addr(coil_addr), .coil_val(coil_val), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_data(reg_data));
   // second slave takes hand-made frames
   mbw_slave #(.VENDOR_STR(VEND), .PRODUCT_STR(PROD), .REVISION_STR(REV)) u_mbw_slave_b (
      .clk(clk), .reset(reset), .own_addr(8'h01), .link(link_b), .coil_wr(),
      .coil_addr(), .coil_val(), .reg_wr(), .reg_addr(), .reg_data());
   mbw_link_checker u_chk (.clk(clk), .reset(reset), .m2s_data(link.m2s_data),
      .m2s_valid(link.m2s_valid), .m2s_last(link.m2s_last), .s2m_data(link.s2m_data),
      .s2m_valid(link.s2m_valid), .s2m_last(link.s2m_last));

   //////////////////////////////
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // capture traffic and strobes; watchdog cuts a hang short
   always @(posedge clk) begin
      if (link.m2s_valid) mq.push_back(link.m2s_data);
      if (rsp_valid) rq.push_back(rsp_data);
      if (link_b.s2m_valid) bq.push_back(link_b.s2m_data);
      if (coil_wr) wq.push_back({coil_addr, 15'h0000, coil_val});
      if (reg_wr) wq.push_back({reg_addr, reg_data});
      cycles++;
      if (cycles > 4000) begin
         failures++;
         end_sim();
      end
   end

   task automatic chk(input string what, input logic [31:0] e, g);
      cmp_count++;
      if (e !== g) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk_q(input string what, input mbw_bq_t e, g);
      chk(what, e.size(), g.size());
      foreach (e[i]) begin
         if (i < g.size()) chk(what, e[i], g[i]);
      end
   endtask
   // own checksum model, kept apart from the design's helper
   function automatic mbw_bq_t with_crc(input mbw_bq_t q);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      return q;
   endfunction
   function automatic mbw_bq_t obj_bytes(input int k);
      mbw_bq_t     q;
      logic [63:0] s;
      int          len;
      s = (k == 0) ? 64'(VEND) : (k == 1) ? PROD : 64'(REV);
      len = (k == 0) ? 4 : (k == 1) ? 8 : 5;
      q = '{8'(k), 8'(len)};
      for (int i = len - 1; i >= 0; i--) q.push_back(s[8*i +: 8]);
      return q;
   endfunction
   // one command through the master, waits for the whole reply
   task automatic run(input logic [7:0] st, fn, input logic [15:0] first, cnt,
                      input logic [63:0] dat, input logic [7:0] rc, ob);
      int n;
      mq.delete();
      rq.delete();
      wq.delete();
      {own_addr, cmd_station, cmd_func, cmd_first, cmd_count} = {st, st, fn, first, cnt};
      {cmd_coils, cmd_regs, cmd_read_code, cmd_object} = {dat[31:0], dat, rc, ob};
      for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(posedge clk) #1;
      cmd_start = 1'b1;
      @(posedge clk) #1 cmd_start = 1'b0;
      for (n = 0; n < 500 && rsp_done !== 1'b1; n++) @(posedge clk) #1;
      @(posedge clk) #1;
      chk("reply checksum flag", 1, rsp_crc_ok);
   endtask
   // raw frame into the second slave, then a fixed listening window
   task automatic send_b(input mbw_bq_t f, e);
      bq.delete();
      foreach (f[i]) begin
         {link_b.m2s_data, link_b.m2s_valid, link_b.m2s_last} = {f[i], 1'b1, i == f.size() - 1};
         @(posedge clk) #1;
      end
      {link_b.m2s_data, link_b.m2s_valid, link_b.m2s_last} = {~f[f.size() - 1], 2'b00};
      repeat (40) @(posedge clk);
      #1 chk_q("raw reply", e, bq);
   endtask
   task automatic end_sim;
      if (failures == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   //////////////////////////////
   initial begin
      mbw_bq_t     e, rsp, bad, none;
      logic [31:0] m;
      logic [7:0]  rc;
      int          nobj;
      {reset, cmd_start, own_addr, cmd_station, cmd_func, cmd_first, cmd_count} = '0;
      {cmd_coils, cmd_regs, cmd_read_code, cmd_object} = '0;
      {link_b.m2s_data, link_b.m2s_valid, link_b.m2s_last} = '0;
      reset = 1'b1;
      repeat (5) @(posedge clk);
      #1 reset = 1'b0;
      // coil writes: example, byte crossing, single bit, widest run
      for (int t = 0; t < 4; t++) begin
         e = '{8'h01, 8'h0F, cf[t][15:8], cf[t][7:0], cn[t][15:8], cn[t][7:0]};
         rsp = with_crc(e);
         m = (cn[t] == 16'h0020) ? cb[t] : cb[t] & ((32'h1 << cn[t]) - 32'h1);
         e.push_back(8'((cn[t] + 16'h0007) >> 3));
         for (int j = 0; j < (cn[t] + 7) / 8; j++) e.push_back(m[8*j +: 8]);
         run(8'h01, 8'h0F, cf[t], cn[t], {32'h0, cb[t]}, 8'h00, 8'h00);
         chk_q("coil request", with_crc(e), mq);
         chk_q("coil reply", rsp, rq);
         chk("coil strobes", cn[t], wq.size());
         foreach (wq[i]) chk("coil write", {16'(cf[t] + i), 15'h0000, m[i]}, wq[i]);
      end
      // register writes: example, single register, four registers
      for (int t = 0; t < 3; t++) begin
         e = '{rs[t], 8'h10, rf[t][15:8], rf[t][7:0], 8'h00, rn[t]};
         rsp = with_crc(e);
         e.push_back(8'(2 * rn[t]));
         for (int j = 0; j < 2 * rn[t]; j++) e.push_back(rv[t][63 - 8*j -: 8]);
         run(rs[t], 8'h10, rf[t], {8'h00, rn[t]}, rv[t], 8'h00, 8'h00);
         chk_q("reg request", with_crc(e), mq);
         chk_q("reg reply", rsp, rq);
         chk("reg strobes", rn[t], wq.size());
         foreach (wq[i]) chk("reg write", {16'(rf[t] + i), rv[t][63 - 16*i -: 16]}, wq[i]);
      end
      // identification: both reading codes from every object
      for (int t = 0; t < 6; t++) begin
         rc = (t < 3) ? 8'h01 : 8'h04;
         nobj = (t < 3) ? 3 - t : 1;
         e = '{8'h01, 8'h2B, 8'h0E, rc, 8'h51, 8'h00, 8'h00, 8'(nobj)};
         for (int k = t % 3; k < t % 3 + nobj; k++) e = {e, obj_bytes(k)};
         run(8'h01, 8'h2B, 16'h0000, 16'h0000, 64'h0, rc, 8'(t % 3));
         chk_q("ident request", with_crc('{8'h01, 8'h2B, 8'h0E, rc, 8'(t % 3)}), mq);
         chk_q("ident reply", with_crc(e), rq);
      end
      // raw frames: good example, then refusals, then recovery
      bad = '{8'h01, 8'h0F, 8'h00, 8'h64, 8'h00, 8'h03, 8'h01, 8'h03, 8'hBE, 8'h9E};
      send_b(bad, '{8'h01, 8'h0F, 8'h00, 8'h64, 8'h00, 8'h03, 8'h54, 8'h15});
      bad[9] = 8'h9F;
      send_b(bad, none);
      send_b(with_crc('{8'h02, 8'h0F, 8'h00, 8'h64, 8'h00, 8'h03, 8'h01, 8'h03}), none);
      send_b(with_crc('{8'h01, 8'h03, 8'h00, 8'h64, 8'h00, 8'h01}), none);
      send_b(with_crc('{8'h01, 8'h2B, 8'h0D, 8'h01, 8'h00}), none);
      send_b(with_crc('{8'h01, 8'h2B, 8'h0E, 8'h02, 8'h00}), none);
      send_b(with_crc('{8'h01, 8'h2B, 8'h0E, 8'h04, 8'h03}), none);
      e = {'{8'h01, 8'h2B, 8'h0E, 8'h04, 8'h51, 8'h00, 8'h00, 8'h01}, obj_bytes(2)};
      send_b(with_crc('{8'h01, 8'h2B, 8'h0E, 8'h04, 8'h02}), with_crc(e));
      end_sim();
   end
endmodule
`default_nettype wire
